// ==== include/mfbt_pkg.sv ====
package mfbt_pkg;
    // Link timing figures
    localparam int IDENT_CLOCK_KHZ      = 400;
    localparam int COMPAT_CLOCK_KHZ     = 26000;
    localparam int HS_CLOCK_KHZ         = 52000;
    localparam int SYS_CLOCK_KHZ        = 250000;
    // Divider half periods in system cycles, rounded up so the limit holds
    localparam int IDENT_HALF = (SYS_CLOCK_KHZ + 2 * IDENT_CLOCK_KHZ - 1) / (2 * IDENT_CLOCK_KHZ);
    localparam int COMPAT_HALF = (SYS_CLOCK_KHZ + 2 * COMPAT_CLOCK_KHZ - 1) / (2 * COMPAT_CLOCK_KHZ);
    localparam int HS_HALF = (SYS_CLOCK_KHZ + 2 * HS_CLOCK_KHZ - 1) / (2 * HS_CLOCK_KHZ);
    localparam int HALF_W = 10;
    // Switch command
    localparam logic [5:0] SWITCH_CMD_INDEX = 6'h06;
    localparam logic [7:0] HS_SELECT_ARG    = 8'h01;
    localparam int         CMD_BITS         = 16;
    localparam logic       START_BIT        = 1'b0;

    typedef enum logic [1:0] {
        MFBT_SPEED_IDENT  = 2'b00,
        MFBT_SPEED_COMPAT = 2'b01,
        MFBT_SPEED_HS     = 2'b10
    } mfbt_speed_e;
endpackage

// ==== include/mfbt_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mfbt_link_if;
    logic       bus_clk;
    logic       cmd_host;
    logic       cmd_host_oe;
    logic       cmd_dev;
    logic       cmd_dev_oe;
    logic [7:0] dat_host;
    logic       dat_host_oe;
    logic [7:0] dat_dev;
    logic       dat_dev_oe;
    logic       ddr_mode;
    wire        cmd_line = cmd_host_oe ? cmd_host : (cmd_dev_oe ? cmd_dev : 1'b1);
    wire  [7:0] dat_line = dat_host_oe ? dat_host : (dat_dev_oe ? dat_dev : 8'hFF);

    modport host (output bus_clk, cmd_host, cmd_host_oe, dat_host, dat_host_oe, ddr_mode,
                  input cmd_line, dat_line);
    modport device (input bus_clk, cmd_line, dat_line, ddr_mode,
                    output cmd_dev, cmd_dev_oe, dat_dev, dat_dev_oe);
endinterface
`default_nettype wire

// ==== design/mfbt_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfbt_device
    import mfbt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    mfbt_link_if.device     link,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            hs_timing
);
    logic [1:0]          clk_s;
    logic [1:0]          cmd_s;
    logic [7:0]          dat_s0;
    logic [7:0]          dat_s1;
    logic [1:0]          ddr_s;
    logic                clk_prev;
    logic                rise;
    logic                fall;
    logic [CMD_BITS-1:0] cmd_sr;
    logic [4:0]          cmd_cnt;
    logic                cmd_busy;

    ////////////////////////////////////////////////////////////////////////
    // Link inputs pass two flops; edges found from the sampled clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_s    <= 2'b00;
            cmd_s    <= 2'b11;
            dat_s0   <= 8'hFF;
            dat_s1   <= 8'hFF;
            ddr_s    <= 2'b00;
            clk_prev <= 1'b0;
        end else begin
            clk_s    <= {clk_s[0], link.bus_clk};
            cmd_s    <= {cmd_s[0], link.cmd_line};
            dat_s0   <= link.dat_line;
            dat_s1   <= dat_s0;
            ddr_s    <= {ddr_s[0], link.ddr_mode};
            clk_prev <= clk_s[1];
        end
    end

    // Edge detection only; a stopped clock just yields no edges
    assign rise = clk_s[1] & ~clk_prev;
    assign fall = ~clk_s[1] & clk_prev;

    ////////////////////////////////////////////////////////////////////////
    // Command receiver, rising edge only in every mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_sr   <= '0;
            cmd_cnt  <= '0;
            cmd_busy <= 1'b0;
        end else if (rise) begin
            if (!cmd_busy) begin
                if (cmd_s[1] == START_BIT) begin
                    cmd_busy <= 1'b1;
                    cmd_cnt  <= 5'h01;
                    cmd_sr   <= '0;
                end
            end else begin
                cmd_sr  <= {cmd_sr[CMD_BITS-2:0], cmd_s[1]};
                cmd_cnt <= cmd_cnt + 5'h01;
                if (cmd_cnt == 5'(CMD_BITS)) begin
                    cmd_busy <= 1'b0;
                end
            end
        end
    end

    // Timing mode: reset to compatible, only the switch command changes it
    // Start bit is not shifted in, so the index sits one place below the prefix
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_timing <= 1'b0;
        end else if (rise && cmd_busy && cmd_cnt == 5'(CMD_BITS)
                     && cmd_sr[CMD_BITS-4:CMD_BITS-9] == SWITCH_CMD_INDEX
                     && {cmd_sr[CMD_BITS-10:0], cmd_s[1]} == HS_SELECT_ARG) begin
            hs_timing <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data: rising edge in single rate, both edges in DDR
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data    <= 8'h00;
            rx_valid   <= 1'b0;
            link.dat_dev    <= 8'hFF;
            link.dat_dev_oe <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (rise || (ddr_s[1] && fall)) begin
                rx_data  <= dat_s1;
                rx_valid <= 1'b1;
                // Launch at the rising edge; DDR also at falling
                link.dat_dev_oe <= tx_valid;
                if (tx_valid) begin
                    link.dat_dev <= tx_data;
                end
            end
        end
    end

    assign tx_ready        = rise || (ddr_s[1] && fall);
    assign link.cmd_dev    = 1'b1;
    assign link.cmd_dev_oe = 1'b0;
endmodule
`default_nettype wire

// ==== design/mfbt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfbt_host
    import mfbt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    mfbt_link_if.host       link,
    input  wire logic       ident_done,
    input  wire logic       switch_req,
    input  wire logic       ddr_req,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output mfbt_speed_e     speed
);
    logic [HALF_W-1:0]   div_cnt;
    logic [HALF_W-1:0]   half;
    logic                edge_en;
    logic [CMD_BITS:0]   cmd_sr;
    logic [4:0]          cmd_left;
    logic [7:0]          dat_s0;
    logic [7:0]          dat_s1;
    logic                sw_pending;

    // Clock limit per phase; speed reaches HS only after the switch goes out
    always_comb begin
        case (speed)
            MFBT_SPEED_IDENT:  half = HALF_W'(IDENT_HALF);
            MFBT_SPEED_COMPAT: half = HALF_W'(COMPAT_HALF);
            default:           half = HALF_W'(HS_HALF);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt      <= '0;
            link.bus_clk <= 1'b0;
        end else if (div_cnt >= half - HALF_W'(1)) begin
            div_cnt      <= '0;
            link.bus_clk <= ~link.bus_clk;
        end else begin
            div_cnt <= div_cnt + HALF_W'(1);
        end
    end
    assign edge_en = (div_cnt >= half - HALF_W'(1));

    // Command shifted out on falling edges only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_sr           <= '1;
            cmd_left         <= '0;
            sw_pending       <= 1'b0;
            speed            <= MFBT_SPEED_IDENT;
            link.cmd_host    <= 1'b1;
            link.cmd_host_oe <= 1'b0;
        end else begin
            if (speed == MFBT_SPEED_IDENT && ident_done) begin
                speed <= MFBT_SPEED_COMPAT;
            end
            if (edge_en && link.bus_clk) begin
                // Falling edge of the bus clock: set up for next rise
                if (cmd_left != '0) begin
                    link.cmd_host    <= cmd_sr[CMD_BITS];
                    link.cmd_host_oe <= 1'b1;
                    cmd_sr           <= {cmd_sr[CMD_BITS-1:0], 1'b1};
                    cmd_left         <= cmd_left - 5'h01;
                end else begin
                    link.cmd_host_oe <= 1'b0;
                    if (sw_pending) begin
                        sw_pending <= 1'b0;
                        speed      <= MFBT_SPEED_HS;
                    end
                end
            end
            if (switch_req && !sw_pending && cmd_left == '0
                && speed == MFBT_SPEED_COMPAT) begin
                cmd_sr     <= {START_BIT, 2'b01, SWITCH_CMD_INDEX, HS_SELECT_ARG};
                cmd_left   <= 5'(CMD_BITS + 1);
                sw_pending <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dat_s0           <= 8'hFF;
            dat_s1           <= 8'hFF;
            rx_data          <= 8'h00;
            rx_valid         <= 1'b0;
            link.dat_host    <= 8'hFF;
            link.dat_host_oe <= 1'b0;
            link.ddr_mode    <= 1'b0;
        end else begin
            dat_s0   <= link.dat_line;
            dat_s1   <= dat_s0;
            rx_valid <= 1'b0;
            link.ddr_mode <= ddr_req && speed == MFBT_SPEED_HS;
            if (edge_en && (!link.bus_clk || link.ddr_mode)) begin
                rx_data          <= dat_s1;
                rx_valid         <= 1'b1;
                link.dat_host_oe <= tx_valid;
                if (tx_valid) begin
                    link.dat_host <= tx_data;
                end
            end
        end
    end
    assign tx_ready = edge_en && (!link.bus_clk || link.ddr_mode);
endmodule
`default_nettype wire

// ==== verification/mfbt_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfbt_link_assertions
    import mfbt_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bus_clk,
    input wire logic cmd_dev_oe,
    input wire logic dat_host_oe,
    input wire logic dat_dev_oe,
    input wire logic ddr_mode,
    input wire logic cmd_line
);
    logic [9:0] stable_cnt;
    logic       frame_seen;
    logic       rise_seen;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Saturates so a stopped link clock cannot wrap the count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stable_cnt <= 10'h000;
        end else if ($changed(bus_clk)) begin
            stable_cnt <= 10'h000;
        end else if (stable_cnt != 10'h3FF) begin
            stable_cnt <= stable_cnt + 10'h001;
        end
    end

    // Start bit seen on a rising link edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_seen <= 1'b0;
            rise_seen  <= 1'b0;
        end else if ($rose(bus_clk)) begin
            rise_seen <= 1'b1;
            if (!cmd_line) begin
                frame_seen <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_ident_first_half: assert property (
        !rise_seen && $rose(bus_clk) |-> int'(stable_cnt) >= IDENT_HALF - 2)
        else $error("link clock too fast during identification");
    a_compat_before_switch: assert property (
        !frame_seen && $changed(bus_clk) |-> int'(stable_cnt) >= COMPAT_HALF - 1)
        else $error("link clock above compatible limit before switch");
    a_clk_high_hold: assert property ($rose(bus_clk) |-> bus_clk [*3])
        else $error("link clock high phase too short");
    a_clk_low_hold: assert property ($fell(bus_clk) |-> !bus_clk [*3])
        else $error("link clock low phase too short");
    a_cmd_on_fall: assert property ($changed(cmd_line) |-> !bus_clk)
        else $error("command line moved while link clock high");
    a_cmd_dev_quiet: assert property (!cmd_dev_oe)
        else $error("device drove the command line");
    a_dat_no_clash: assert property (!(dat_host_oe && dat_dev_oe))
        else $error("both ends drive the data lines");
    a_ddr_after_switch: assert property ($rose(ddr_mode) |-> frame_seen)
        else $error("double rate entered before switch command");
endmodule
`default_nettype wire

// ==== verification/test_managed_flash_bus_timing_modes.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_managed_flash_bus_timing_modes
    import mfbt_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ident_done = 1'b0;
    logic        switch_req = 1'b0;
    logic        ddr_req = 1'b0;
    logic [7:0]  h_tx_data = 8'h00;
    logic        h_tx_valid = 1'b0;
    logic        h_tx_ready;
    logic [7:0]  h_rx_data;
    logic        h_rx_valid;
    mfbt_speed_e speed;
    logic [7:0]  d_tx_data = 8'h00;
    logic        d_tx_valid = 1'b0;
    logic        d_tx_ready;
    logic [7:0]  d_rx_data;
    logic        d_rx_valid;
    logic        hs_timing;
    int          n_errors = 0;
    int          cmp_count = 0;
    logic [31:0] n;
    int          k;

    always #2 clk = ~clk;

    mfbt_link_if link();
    mfbt_host mfbt_host_i (.clk(clk), .arst_n(arst_n), .link(link), .ident_done(ident_done),
        .switch_req(switch_req), .ddr_req(ddr_req), .tx_data(h_tx_data), .tx_valid(h_tx_valid),
        .tx_ready(h_tx_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid), .speed(speed));
    mfbt_device mfbt_device_i (.clk(clk), .arst_n(arst_n), .link(link), .tx_data(d_tx_data),
        .tx_valid(d_tx_valid), .tx_ready(d_tx_ready), .rx_data(d_rx_data),
        .rx_valid(d_rx_valid), .hs_timing(hs_timing));
    mfbt_link_assertions mfbt_link_assertions_i (.clk(clk), .arst_n(arst_n),
        .bus_clk(link.bus_clk), .cmd_dev_oe(link.cmd_dev_oe), .dat_host_oe(link.dat_host_oe),
        .dat_dev_oe(link.dat_dev_oe), .ddr_mode(link.ddr_mode), .cmd_line(link.cmd_line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Skips the partial half in progress, then counts one whole half
    task automatic half_period(output logic [31:0] c);
        logic lvl;
        int   j;
        lvl = link.bus_clk;
        for (j = 0; j < 2000 && link.bus_clk === lvl; j++) begin
            @(posedge clk);
            #1;
        end
        lvl = link.bus_clk;
        for (c = 0; c < 2000 && link.bus_clk === lvl; c++) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic wait_speed(input mfbt_speed_e s);
        int j;
        for (j = 0; j < 2000 && speed !== s; j++) @(posedge clk);
        #1;
    endtask

    // Valid held through the edge at which ready stands high
    task automatic xfer(input logic to_dev, input logic [7:0] b);
        int j;
        @(posedge clk);
        #1;
        if (to_dev) begin
            h_tx_data = b;
            h_tx_valid = 1'b1;
        end else begin
            d_tx_data = b;
            d_tx_valid = 1'b1;
        end
        for (j = 0; j < 500 && (to_dev ? h_tx_ready : d_tx_ready) !== 1'b1; j++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        h_tx_valid = 1'b0;
        d_tx_valid = 1'b0;
        for (j = 0; j < 500 && (to_dev ? d_rx_valid : h_rx_valid) !== 1'b1; j++) begin
            @(posedge clk);
            #1;
        end
        check(to_dev ? d_rx_data : h_rx_data, b);
    endtask

    // Edges delivered to the device in a window, host streaming
    task automatic count_rx(input int cyc, output logic [31:0] c);
        c = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (d_rx_valid === 1'b1) begin
                c++;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #60000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        check(speed, MFBT_SPEED_IDENT);
        check(hs_timing, 1'b0);
        half_period(n);
        check(n, IDENT_HALF);
        ident_done = 1'b1;
        wait_speed(MFBT_SPEED_COMPAT);
        check(speed, MFBT_SPEED_COMPAT);
        half_period(n);
        check(n, COMPAT_HALF);
        xfer(1'b1, 8'h5A);
        xfer(1'b0, 8'hC3);
        check(hs_timing, 1'b0);
        switch_req = 1'b1;
        for (k = 0; k < 1000 && hs_timing !== 1'b1; k++) @(posedge clk);
        check(hs_timing, 1'b1);
        wait_speed(MFBT_SPEED_HS);
        check(speed, MFBT_SPEED_HS);
        half_period(n);
        check(n, HS_HALF);
        xfer(1'b1, 8'hA5);
        xfer(1'b0, 8'h3C);
        // Window of ten link periods: one byte per period, then two
        h_tx_data = 8'h96;
        h_tx_valid = 1'b1;
        count_rx(60, n);
        check(n >= 9 && n <= 11, 1'b1);
        ddr_req = 1'b1;
        repeat (20) @(posedge clk);
        count_rx(60, n);
        check(n >= 19 && n <= 21, 1'b1);
        check(d_rx_data, 8'h96);
        h_tx_valid = 1'b0;
        ident_done = 1'b0;
        switch_req = 1'b0;
        ddr_req = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        check(speed, MFBT_SPEED_IDENT);
        check(hs_timing, 1'b0);
        // Second release: link must restart at the identification rate
        #1;
        arst_n = 1'b1;
        half_period(n);
        check(n, IDENT_HALF);
        check(hs_timing, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
